// ==== rtl/cpp_defines.vh ====
// Constants for the coprocessor parallel port.
`ifndef CPP_DEFINES_VH
`define CPP_DEFINES_VH
`define CPP_DATA_W 16
`define CPP_PORT_W 3
`define CPP_ADDR_W 12
`define CPP_ZERO_WORD 16'h0000
`define CPP_TX_FULL_RST 1'b0
`define CPP_RX_EMPTY_RST 1'b1
`define CPP_SYNC_STAGES 3
`endif

// ==== rtl/cpp_port.v ====
// Parallel I/O port and coprocessor latch logic of a signal processor.
`timescale 1ns/100ps
`include "cpp_defines.vh"

module cpp_port (
  input wire clock,
  input wire rst,
  // Core side.
  input wire core_rd,
  input wire core_wr,
  input wire [`CPP_PORT_W-1:0] core_port,
  input wire [`CPP_DATA_W-1:0] core_wdata,
  output reg [`CPP_DATA_W-1:0] core_rdata,
  output wire core_irq,
  output wire branch_on_test_low,
  // Mode straps.
  input wire port_mode_select,
  input wire slave_mode,
  input wire byte_mode,
  // Plain I/O bus pins.
  output reg [`CPP_ADDR_W-1:0] io_addr,
  output reg io_read_strobe_n,
  output reg io_write_strobe_n,
  input wire [`CPP_DATA_W-1:0] io_data_in,
  output reg [`CPP_DATA_W-1:0] io_data_out,
  output reg io_data_oe,
  // Coprocessor host pins.
  input wire host_rd_n,
  input wire host_wr_n,
  input wire byte_half_select,
  input wire [`CPP_DATA_W-1:0] host_data_in,
  output wire [`CPP_DATA_W-1:0] host_data_out,
  output wire host_data_oe,
  output wire tx_latch_full_n,
  output wire rx_latch_empty_n,
  output wire branch_test_input_n
);

  // How the two halves of the block fit together.
  // The plain port path and the coprocessor path share the core strobes.
  // The mode pin decides which of the two sees a core access.
  // In coprocessor mode the shared bus strobes stay idle, so nothing
  // outside can mistake a latch access for a plain port cycle.
  // The host side runs on its own strobes, with no clock of its own.
  // Every host strobe is therefore treated as asynchronous here.
  // Data on the host bus is taken only when the trailing edge is seen,
  // so the host must hold its data until the synchroniser has caught up.
  // The price is a few cycles of latency on every flag change that a host strobe causes.
  // A host that is faster than this must stretch its strobes.
  // Flags are plain levels and never pulse; firmware may poll them.
  // The interrupt request is a level as well, held until the core reads.
  // The branch test level is held until the core writes the latch again.
  // Neither the latch contents nor the flags are protected against a
  // host that breaks the ordering rules; the later event simply wins.

  ////////////////////////////////////////////////////////////////////////
  // Synchronisers: three stages, change counts once stages 2 and 3 agree.
  reg [2:0] rd_sync_reg;
  reg [2:0] wr_sync_reg;
  reg rd_state_reg;
  reg wr_state_reg;
  wire host_rd_done;
  wire host_wr_done;

  always @(posedge clock) begin
    if (rst) begin
      rd_sync_reg <= 3'h0;
      wr_sync_reg <= 3'h0;
      rd_state_reg <= 1'b0;
      wr_state_reg <= 1'b0;
    end else begin
      rd_sync_reg <= {rd_sync_reg[1:0], ~host_rd_n};
      wr_sync_reg <= {wr_sync_reg[1:0], ~host_wr_n};
      if (rd_sync_reg[1] == rd_sync_reg[2])
        rd_state_reg <= rd_sync_reg[2];
      if (wr_sync_reg[1] == wr_sync_reg[2])
        wr_state_reg <= wr_sync_reg[2];
    end
  end

  // An access counts as finished on the trailing edge of its strobe.
  assign host_rd_done = rd_state_reg & ~rd_sync_reg[2] & ~rd_sync_reg[1];
  assign host_wr_done = wr_state_reg & ~wr_sync_reg[2] & ~wr_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////
  // Byte merge helper for 8-bit host writes.
  // The other half keeps its value, so two byte writes build one word.
  // The receive latch is zeroed on a coprocessor-mode core read unless a host
  // write ends in that cycle, which keeps a lone
  // byte write from mixing with stale data of an earlier word.
  function [`CPP_DATA_W-1:0] merge_byte;
    input [`CPP_DATA_W-1:0] old_word;
    input [7:0] new_byte;
    input high_half;
    begin
      if (high_half)
        merge_byte = {new_byte, old_word[7:0]};
      else
        merge_byte = {old_word[15:8], new_byte};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Coprocessor latches and flags.
  reg [`CPP_DATA_W-1:0] tx_latch_reg;
  reg [`CPP_DATA_W-1:0] rx_latch_reg;
  reg tx_full_reg;
  reg rx_empty_reg;
  reg irq_reg;
  reg test_low_reg;
  wire cop_mode;
  wire core_cop_wr;
  wire core_cop_rd;

  assign cop_mode = port_mode_select;
  assign core_cop_wr = cop_mode & core_wr;
  assign core_cop_rd = cop_mode & core_rd;

  // Latches and flags; a core write beats a same-cycle host read for tx_full_reg, host events win everywhere else.
  always @(posedge clock) begin
    if (rst) begin
      tx_latch_reg <= `CPP_ZERO_WORD;
      rx_latch_reg <= `CPP_ZERO_WORD;
      tx_full_reg <= `CPP_TX_FULL_RST;
      rx_empty_reg <= `CPP_RX_EMPTY_RST;
      irq_reg <= 1'b0;
      test_low_reg <= 1'b0;
    end else begin
      if (core_cop_wr) begin
        tx_latch_reg <= core_wdata;
        tx_full_reg <= 1'b1;
      end else if (cop_mode && host_rd_done) begin
        tx_full_reg <= 1'b0;
      end
      if (cop_mode && host_wr_done) begin
        if (byte_mode)
          rx_latch_reg <= merge_byte(rx_latch_reg, host_data_in[7:0],
                                     byte_half_select);
        else
          rx_latch_reg <= host_data_in;
        rx_empty_reg <= 1'b0;
      end else if (core_cop_rd) begin
        rx_latch_reg <= `CPP_ZERO_WORD;
        rx_empty_reg <= 1'b1;
      end
      if (cop_mode && slave_mode && host_wr_done)
        irq_reg <= 1'b1;
      else if (core_cop_rd)
        irq_reg <= 1'b0;
      if (cop_mode && slave_mode && host_rd_done)
        test_low_reg <= 1'b1;
      else if (core_cop_wr)
        test_low_reg <= 1'b0;
    end
  end

  assign core_irq = irq_reg;
  assign branch_on_test_low = test_low_reg;
  assign branch_test_input_n = ~test_low_reg;
  assign tx_latch_full_n = ~tx_full_reg;
  assign rx_latch_empty_n = ~rx_empty_reg;

  assign host_data_out = (byte_mode && byte_half_select) ?
                         {8'h00, tx_latch_reg[15:8]} : tx_latch_reg;
  assign host_data_oe = cop_mode & ~host_rd_n;

  ////////////////////////////////////////////////////////////////////////
  // Plain port cycles on the shared bus, registered for one cycle.
  always @(posedge clock) begin
    if (rst) begin
      io_addr <= {`CPP_ADDR_W{1'b0}};
      io_read_strobe_n <= 1'b1;
      io_write_strobe_n <= 1'b1;
      io_data_out <= `CPP_ZERO_WORD;
      io_data_oe <= 1'b0;
    end else begin
      io_addr <= {{(`CPP_ADDR_W-`CPP_PORT_W){1'b0}}, core_port};
      io_read_strobe_n <= ~(core_rd & ~cop_mode);
      io_write_strobe_n <= ~(core_wr & ~cop_mode);
      io_data_out <= core_wdata;
      io_data_oe <= core_wr & ~cop_mode;
    end
  end

  // Core read data: latch in coprocessor mode, else bus sample.
  always @(posedge clock) begin
    if (rst)
      core_rdata <= `CPP_ZERO_WORD;
    else if (core_rd)
      core_rdata <= cop_mode ? rx_latch_reg : io_data_in;
  end

endmodule

// ==== verification/cpp_port_chk.sv ====
// Pin-level assertions for the coprocessor parallel port.
`timescale 1ns/100ps
module cpp_port_chk(input wire clock, input wire rst, input wire core_rd,
  input wire core_wr, input wire [2:0] core_port, input wire slave_mode,
  input wire port_mode_select, input wire [11:0] io_addr,
  input wire io_read_strobe_n, input wire io_write_strobe_n,
  input wire io_data_oe, input wire host_wr_n, input wire core_irq,
  input wire tx_latch_full_n, input wire rx_latch_empty_n,
  input wire host_rd_n, input wire host_data_oe,
  input wire branch_on_test_low, input wire branch_test_input_n);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire m = port_mode_select;
  // A host write ends when its strobe returns high.
  sequence s_hw_end; m && $rose(host_wr_n); endsequence
  property p_wr; !m && core_wr |=> !io_write_strobe_n && io_data_oe;
  endproperty
  a_wr: assert property (p_wr) else $error("write strobe missing");
  property p_rd; !m && core_rd |=> !io_read_strobe_n; endproperty
  a_rd: assert property (p_rd) else $error("read strobe missing");
  property p_adr; !m && core_wr |=> io_addr == {9'h000, $past(core_port)};
  endproperty
  a_adr: assert property (p_adr) else $error("bad port address");
  property p_cop; m && $past(m) |-> io_read_strobe_n && io_write_strobe_n;
  endproperty
  a_cop: assert property (p_cop) else $error("plain strobe in cop");
  property p_full; m && core_wr |=> !tx_latch_full_n; endproperty
  a_full: assert property (p_full) else $error("full flag not set");
  property p_emp; m && core_rd && host_wr_n |=> !rx_latch_empty_n;
  endproperty
  a_emp: assert property (p_emp) else $error("empty flag not set");
  property p_irq; m && slave_mode && $rose(rx_latch_empty_n) |-> core_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("no interrupt");
  property p_sync; s_hw_end |-> ##[2:6] rx_latch_empty_n; endproperty
  a_sync: assert property (p_sync) else $error("host write lost");
  property p_oe; host_data_oe == (m && !host_rd_n); endproperty
  a_oe: assert property (p_oe) else $error("host drive wrong");
  property p_tst; $rose(branch_on_test_low) |-> m && slave_mode &&
    tx_latch_full_n && !branch_test_input_n; endproperty
  a_tst: assert property (p_tst) else $error("bad test level");
endmodule
bind cpp_port cpp_port_chk CHK(.clock, .rst, .core_rd, .core_wr,
  .core_port, .slave_mode, .port_mode_select, .io_addr, .io_read_strobe_n,
  .io_write_strobe_n, .io_data_oe, .host_wr_n, .core_irq,
  .tx_latch_full_n, .rx_latch_empty_n, .host_rd_n, .host_data_oe,
  .branch_on_test_low, .branch_test_input_n);

// ==== verification/cpp_host_model.sv ====
// Behavioural host processor on the coprocessor pins.
`timescale 1ns/100ps
module cpp_host_model(input wire clock, output reg host_rd_n,
  output reg host_wr_n, output reg byte_half_select,
  output reg [15:0] host_data_in);
  initial begin
    {host_rd_n, host_wr_n, byte_half_select} = 3'h6;
    host_data_in = 16'hFFFF;
  end
  // keeps latch filled
  // Data holds past the strobe so the synchroniser sees it; then it is junk.
  task wr(input [15:0] d, input h);
    @(negedge clock);
    {byte_half_select, host_data_in, host_wr_n} = {h, d, 1'b0};
    repeat (4) @(negedge clock);
    host_wr_n = 1;
    repeat (4) @(negedge clock);
    host_data_in = ~d;
  endtask
  task rd(input h);
    @(negedge clock);
    {byte_half_select, host_rd_n} = {h, 1'b0};
    repeat (4) @(negedge clock);
    host_rd_n = 1;
    repeat (4) @(negedge clock);
  endtask
endmodule

// ==== verification/tb.sv ====
// Self-checking bench for the coprocessor parallel port.
`timescale 1ns/100ps
module tb;
  reg clock = 0, rst = 1, core_rd = 0, core_wr = 0, probe = 0, rd_d = 0;
  reg port_mode_select = 0, slave_mode = 1, byte_mode = 0, hr_d = 1;
  reg [2:0] core_port = 0;
  reg [15:0] core_wdata = 0, io_data_in = 0, w;
  wire [15:0] core_rdata, io_data_out, host_data_in, host_data_out;
  wire [11:0] io_addr;
  wire core_irq, branch_on_test_low, io_read_strobe_n, io_write_strobe_n;
  wire io_data_oe, host_rd_n, host_wr_n, byte_half_select, host_data_oe;
  wire tx_latch_full_n, rx_latch_empty_n, branch_test_input_n;
  int mismatches = 0, compares = 0, i;
  logic [27:0] exp_q[$];
  always #5 clock = ~clock;
  cpp_port DUT(.*);
  cpp_host_model HOST(.*);
  task print_verdict;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task cmp(input [27:0] got);
    compares++;
    if (got !== exp_q[0]) begin
      mismatches++;
      $display("wrong value at %0t: %h, %h", $time, got, exp_q[0]);
    end
    void'(exp_q.pop_front());
  endtask
  task pulse(input wr, input [2:0] p, input [15:0] d);
    @(negedge clock);
    {core_wr, core_rd, core_port, core_wdata} = {wr, !wr, p, d};
    @(negedge clock);
    {core_wr, core_rd} = 2'h0;
  endtask
  // Flags are read once the synchronisers have long settled.
  task flags(input [3:0] f);
    repeat (8) @(negedge clock);
    exp_q.push_back({24'h0, f});
    probe = 1;
    @(negedge clock);
    probe = 0;
  endtask
  // Match each result, as it appears, against the oldest note.
  always @(posedge clock) begin
    rd_d <= core_rd;
    hr_d <= host_rd_n;
    if (!io_write_strobe_n) cmp({io_addr, io_data_out});
    if (rd_d) cmp({12'h0, core_rdata});
    if (host_rd_n && !hr_d) cmp({12'h0, host_data_out});
    if (probe) cmp({24'h0, tx_latch_full_n, rx_latch_empty_n,
      branch_test_input_n, core_irq});
  end
  initial begin
    #100000 mismatches++;
    print_verdict;
  end
  // Plain ports first, then slave and master coprocessor traffic.
  initial begin
    void'($urandom(77));
    repeat (4) @(negedge clock);
    rst = 0;
    for (i = 0; i < 8; i++) begin
      w = $urandom;
      exp_q.push_back({9'h000, i[2:0], w});
      pulse(1, i[2:0], w);
    end
    io_data_in = $urandom;
    exp_q.push_back({12'h0, io_data_in});
    pulse(0, 3'h5, 0);
    port_mode_select = 1;
    flags(4'hA);
    w = $urandom;
    HOST.wr(w, 0);
    flags(4'hF);
    exp_q.push_back({12'h0, w});
    pulse(0, 0, 0);
    flags(4'hA);
    exp_q.push_back(0);
    pulse(0, 0, 0);
    w = $urandom;
    pulse(1, 0, w);
    flags(4'h2);
    exp_q.push_back({12'h0, w});
    HOST.rd(0);
    flags(4'h8);
    {slave_mode, byte_mode} = 2'h1;
    HOST.wr(16'h00A5, 1);
    HOST.wr(16'h003C, 0);
    exp_q.push_back(28'h000A53C);
    pulse(0, 0, 0);
    flags(4'h8);
    w = $urandom;
    pulse(1, 0, w);
    exp_q.push_back({20'h0, w[15:8]});
    HOST.rd(1);
    flags(4'hA);
    print_verdict;
  end
endmodule
